//--- hdl/shift_move_datapath.sv
// datapath slice executing shift left, shift right and register move
//
// How it works
// - left shift moves bits 6:0 up, zero in
// - left shift puts old bit 7 in carry
// - right shift moves bits 7:1 down, zero in
// - right shift puts old bit 0 in carry
// - shift result to accumulator or file by dest
// - move copies file to accumulator or itself
// - move updates zero flag from moved value
`timescale 1ns/10ps
`default_nettype none

module shift_move_datapath (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire shift_move_pkg::instr_t  instr,
  output var  logic [7:0]              accum,
  output var  logic                    carry,
  output var  logic                    zero,
  output var  shift_move_pkg::file_wr_t file_wr,
  output var  logic                    done
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks
  // the port structs fix one byte of data and a seven bit address;
  // a package edit that breaks either would misroute bits silently
  if (shift_move_pkg::DATA_W != $bits(accum)) begin : g_bad_data_w
    $error("data width does not match the accumulator port");
  end
  if ($bits(instr.operand) != $bits(accum)) begin : g_bad_operand_w
    $error("operand width does not match the accumulator port");
  end
  if (shift_move_pkg::ADDR_W != $bits(file_wr.addr)) begin : g_bad_addr_w
    $error("address width does not match the file write port");
  end
  // the carry taps sit at the two ends of the byte
  if (shift_move_pkg::MSB_POS != shift_move_pkg::DATA_W - 1) begin : g_bad_msb
    $error("top bit position is not the last data bit");
  end
  if (shift_move_pkg::LSB_POS != 0) begin : g_bad_lsb
    $error("bottom bit position is not bit zero");
  end
  // the destination bit needs two distinct meanings
  if (shift_move_pkg::DEST_ACCUM == shift_move_pkg::DEST_FILE) begin : g_bad_dest
    $error("both destination codes are equal");
  end

  ////////////////////////////////////////////////////////////////////////
  // shift, flag and decode helpers
  // kept as functions so the shift taps and the decode sit in one place

  function automatic logic [7:0] shift_left_value(input logic [7:0] value);
    // bits 6:0 move up one place, zero into bit 0
    shift_left_value = {value[shift_move_pkg::MSB_POS-1:shift_move_pkg::LSB_POS], 1'h0};
  endfunction

  function automatic logic shift_left_carry(input logic [7:0] value);
    // the top bit falls off the left end
    shift_left_carry = value[shift_move_pkg::MSB_POS];
  endfunction

  function automatic logic [7:0] shift_right_value(input logic [7:0] value);
    // bits 7:1 move down one place, zero into bit 7
    shift_right_value = {1'h0, value[shift_move_pkg::MSB_POS:shift_move_pkg::LSB_POS+1]};
  endfunction

  function automatic logic shift_right_carry(input logic [7:0] value);
    // the bottom bit falls off the right end
    shift_right_carry = value[shift_move_pkg::LSB_POS];
  endfunction

  function automatic logic is_zero(input logic [7:0] value);
    // no bit set anywhere in the byte
    is_zero = ~|value;
  endfunction

  // left shift op code
  function automatic logic is_shift_left(input shift_move_pkg::op_t op);
    is_shift_left = (op == shift_move_pkg::shift_left_op);
  endfunction

  // right shift op code
  function automatic logic is_shift_right(input shift_move_pkg::op_t op);
    is_shift_right = (op == shift_move_pkg::shift_right_op);
  endfunction

  function automatic logic is_file_dest(input logic dest);
    is_file_dest = (dest == shift_move_pkg::DEST_FILE);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // block state and decoded instruction
  shift_move_pkg::state_t state_ff;     // all registered state
  shift_move_pkg::state_t nxt_state;    // value for the next edge
  logic                   take_left;    // left shift taken this edge
  logic                   take_right;   // right shift taken this edge
  logic                   take_shift;   // either shift taken this edge
  logic                   take_move;    // move taken this edge
  logic                   to_file;      // result goes back to the file
  logic [7:0]             result;       // value headed for the destination
  logic                   shifted_out;  // carry value for the next edge

  ////////////////////////////////////////////////////////////////////////
  // instruction decode
  // op code 2 has no instruction of its own and runs as a move, so a
  // stray code leaves carry alone but writes the operand and updates the zero flag
  always_comb begin
    take_left  = 1'h0;
    take_right = 1'h0;
    take_move  = 1'h0;
    to_file    = 1'h0;
    if (instr.valid) begin
      take_left  = is_shift_left(instr.op);
      take_right = is_shift_right(instr.op);
      take_move  = !take_left && !take_right;
      to_file    = is_file_dest(instr.dest);
    end
  end

  // either shift loads the carry
  assign take_shift = take_left || take_right;

  ////////////////////////////////////////////////////////////////////////
  // result and shifted out bit
  // the move path passes the operand through and hands the old carry on
  always_comb begin
    result      = instr.operand;
    shifted_out = state_ff.carry;
    if (take_left) begin
      result      = shift_left_value(instr.operand);
      shifted_out = shift_left_carry(instr.operand);
    end else if (take_right) begin
      result      = shift_right_value(instr.operand);
      shifted_out = shift_right_carry(instr.operand);
    end else begin
      result      = instr.operand;
      shifted_out = state_ff.carry; // move leaves carry alone
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  // pulses drop back every cycle; accumulator, flags and the last file
  // write hold until an instruction replaces them
  always_comb begin
    nxt_state            = state_ff;
    nxt_state.file_wr.we = 1'h0;

    nxt_state.done = instr.valid;

    // carry from shifts
    // a move and op code 2 leave the carry as it stands
    if (take_shift) begin
      nxt_state.carry = shifted_out;
    end

    if (take_shift || take_move) begin
      nxt_state.zero = is_zero(result);
    end

    if (instr.valid && to_file) begin
      nxt_state.file_wr.we   = 1'h1;
      nxt_state.file_wr.addr = instr.addr;
      nxt_state.file_wr.data = result;
    end

    // accumulator loads only when the result is not headed for the file
    if (instr.valid && !to_file) begin
      nxt_state.accum = result;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  // reset loads constants only, so no input can reach the reset branch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff.accum        <= shift_move_pkg::DATA_RESET;
      state_ff.carry        <= 1'h0;
      state_ff.zero         <= 1'h0;
      state_ff.file_wr.we   <= 1'h0;
      state_ff.file_wr.addr <= shift_move_pkg::ADDR_RESET;
      state_ff.file_wr.data <= shift_move_pkg::DATA_RESET;
      state_ff.done         <= 1'h0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  // file write strobe and done last one cycle; the rest hold
  // the file side must take address and data while the strobe is high
  assign accum   = state_ff.accum;
  assign carry   = state_ff.carry;
  assign zero    = state_ff.zero;
  assign file_wr = state_ff.file_wr;
  assign done    = state_ff.done;

endmodule

`default_nettype wire

//--- hdl/shift_move_pkg.sv
// shared types and constants for the shift and move datapath slice
package shift_move_pkg;

  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ADDR_W     = 7;
  localparam int unsigned MSB_POS    = 7;
  localparam int unsigned LSB_POS    = 0;
  localparam logic [7:0]  DATA_RESET = 8'h00;
  localparam logic [6:0]  ADDR_RESET = 7'h00;
  localparam logic        DEST_ACCUM = 1'b0;
  localparam logic        DEST_FILE  = 1'b1;

  // operation select
  typedef enum logic [1:0] {
    copy_register_op = 2'h0,
    shift_left_op    = 2'h1,
    shift_right_op   = 2'h3
  } op_t;

  // one issued instruction
  typedef struct packed {
    logic       valid;
    op_t        op;
    logic       dest;
    logic [6:0] addr;
    logic [7:0] operand;
  } instr_t;

  // register file write back
  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } file_wr_t;

  // complete block state
  typedef struct packed {
    logic [7:0] accum;
    logic       carry;
    logic       zero;
    file_wr_t   file_wr;
    logic       done;
  } state_t;

endpackage

//--- testbench/smd_properties.sv
// checker for the shift and move datapath ports
`timescale 1ns/10ps
`default_nettype none
module smd_check (
  input wire logic                     clk,
  input wire logic                     nrst,
  input wire shift_move_pkg::instr_t   instr,
  input wire logic [7:0]               accum,
  input wire logic                     carry,
  input wire logic                     zero,
  input wire shift_move_pkg::file_wr_t file_wr,
  input wire logic                     done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // decoded ops and visible result
  wire sl = instr.valid && instr.op == shift_move_pkg::shift_left_op;
  wire sr = instr.valid && instr.op == shift_move_pkg::shift_right_op;
  wire mv = instr.valid && !sl && !sr;
  wire logic [7:0] res = file_wr.we ? file_wr.data : accum;
  sl_data_a:
    assert property (sl |=> res == {$past(instr.operand[6:0]), 1'h0}) else $error("left data");
  sl_carry_a:
    assert property (sl |=> carry == $past(instr.operand[7])) else $error("left carry");
  sr_data_a:
    assert property (sr |=> res == {1'h0, $past(instr.operand[7:1])}) else $error("right data");
  sr_carry_a:
    assert property (sr |=> carry == $past(instr.operand[0])) else $error("right carry");
  dest_sel_a:
    assert property (instr.valid |=> file_wr.we == $past(instr.dest)) else $error("dest select");
  mv_data_a:
    assert property (mv |=> res == $past(instr.operand) && $stable(carry)) else $error("move data");
  mv_zero_a:
    assert property (mv |=> zero == ($past(instr.operand) == 8'h00)) else $error("move zero");
  zero_res_a:
    assert property (instr.valid |=> done && zero == (res == 8'h00)) else $error("zero flag");
  cover property (sl && instr.dest);
  cover property (sr && !instr.dest);
  file_addr_a:
    assert property (instr.valid && instr.dest |=> file_wr.addr == $past(instr.addr)) else $error("file address");
  accum_hold_a:
    assert property (instr.valid && instr.dest |=> $stable(accum)) else $error("accum hold");
  idle_hold_a:
    assert property (!instr.valid |=> !done && !file_wr.we && $stable(accum) && $stable(carry) && $stable(zero))
      else $error("idle hold");
  cover property (mv && instr.operand == 8'h00);
  cover property (instr.valid && instr.op == shift_move_pkg::op_t'(2'h2));
endmodule
bind shift_move_datapath smd_check chk (.clk(clk), .nrst(nrst), .instr(instr), .accum(accum),
  .carry(carry), .zero(zero), .file_wr(file_wr), .done(done));
`default_nettype wire

//--- testbench/tb_shift_move_datapath.sv
// testbench for the shift and move datapath
`timescale 1ns/10ps
`default_nettype none
module tb_shift_move_datapath;
  logic                     clk = 1'h0;
  logic                     nrst = 1'h0;
  shift_move_pkg::instr_t   instr = '0;
  logic [7:0]               accum, r;
  logic [7:0]               a_exp = 8'h00;
  logic                     carry, zero, done;
  shift_move_pkg::file_wr_t file_wr;
  int                       fails = 0, checks_done = 0;
  shift_move_datapath dut (.clk(clk), .nrst(nrst), .instr(instr), .accum(accum), .carry(carry),
    .zero(zero), .file_wr(file_wr), .done(done));
  always #20 clk = ~clk;
  // issue one op, then judge result, dest, carry, zero
  task ex(shift_move_pkg::op_t op, logic d, logic [7:0] x, logic [7:0] e, logic c);
    @(posedge clk) #1;
    instr = {1'h1, op, d, ~x[6:0], x};
    @(posedge clk) #1;
    instr.valid = 1'h0;
    r = d ? file_wr.data : accum;
    if (!d)
      a_exp = e;
    checks_done++;
    if ({r, carry, zero, file_wr.we, done, accum} !== {e, c, e == 8'h00, d, 1'h1, a_exp}) begin
      fails++;
      $display("Error result exp %h %h %h got %h %h %h %h %h", e, c, a_exp, r, carry, zero, file_wr.we, accum);
    end
    if (d && file_wr.addr !== ~x[6:0]) begin
      fails++;
      $display("Error file address exp %h got %h", ~x[6:0], file_wr.addr);
    end
  endtask
  // pulse reset mid-run, then judge every output against its reset value
  task t_reset;
    @(posedge clk) #1;
    nrst = 1'h0;
    @(posedge clk) #1;
    nrst = 1'h1;
    a_exp = shift_move_pkg::DATA_RESET;
    checks_done++;
    if ({accum, carry, zero, file_wr, done} !== {shift_move_pkg::DATA_RESET, 2'h0, 1'h0, shift_move_pkg::ADDR_RESET,
        shift_move_pkg::DATA_RESET, 1'h0}) begin
      fails++;
      $display("Error reset state exp 0 got %h %h %h %h %h", accum, carry, zero, file_wr, done);
    end
  endtask
  task t_left;
    ex(shift_move_pkg::shift_left_op, 1'h1, 8'h81, 8'h02, 1'h1);
    ex(shift_move_pkg::shift_left_op, 1'h0, 8'h80, 8'h00, 1'h1);
  endtask
  task t_right;
    ex(shift_move_pkg::shift_right_op, 1'h0, 8'h01, 8'h00, 1'h1);
    ex(shift_move_pkg::shift_right_op, 1'h1, 8'hFE, 8'h7F, 1'h0);
  endtask
  task t_move;
    ex(shift_move_pkg::shift_left_op, 1'h0, 8'hC0, 8'h80, 1'h1);
    ex(shift_move_pkg::copy_register_op, 1'h1, 8'h00, 8'h00, 1'h1);
    ex(shift_move_pkg::copy_register_op, 1'h0, 8'hA5, 8'hA5, 1'h1);
    ex(shift_move_pkg::op_t'(2'h2), 1'h0, 8'h3C, 8'h3C, 1'h1);
  endtask
  task close_out;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #20000;
    fails++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 nrst = 1'h1;
    t_left();
    t_reset();
    t_right();
    t_move();
    close_out();
  end
endmodule
`default_nettype wire
